// file: interrupt_enable_priority_logic.v
`include "intc_map.vh"
// Maskable interrupt enables, request latches, level arbitration and
// acceptance sequencing toward the core.
module interrupt_enable_priority_logic (
  // Clock and reset
  input  wire        clk,
  input  wire        rst_n,
  input  wire        ce,
  // Register port from the core
  input  wire [11:0] addr,
  input  wire        wr_en,
  input  wire        rd_en,
  input  wire [7:0]  wdata,
  output reg  [7:0]  rdata_r,
  // Request pulses from sources 4 to 25, bit n is source n
  input  wire [25:0] src_request,
  input  wire        nonmask_request,
  // Core sequencing
  input  wire        instr_boundary,
  input  wire        machine_cycle,
  input  wire        maskable_return,
  input  wire        nonmaskable_return,
  input  wire        restored_master,
  // Status toward the core
  output reg  [4:0]  winner_index_r,
  output reg         winner_valid_r,
  output reg         accept_busy_r,
  output reg         push_strobe_r,
  output reg  [1:0]  push_count_r,
  output reg         vector_load_r,
  output reg  [4:0]  vector_index_r,
  output reg         in_service_r,
  output wire        master_enable
);
  // Sequencer states: idle, running an acceptance, serving a routine.
  localparam ST_IDLE   = 2'h0;
  localparam ST_ACCEPT = 2'h1;
  localparam ST_SERVE  = 2'h2;
  localparam NSRC      = 26;

  // Flags and latches use bit n for source n; bits 3 to 0 always stay zero.
  reg  [25:0] source_enable_flag_r;
  reg  [25:0] request_latch_r;
  reg         master_enable_r;
  reg         nonmask_pending_r;
  reg  [1:0]  state_r;
  reg  [3:0]  cycle_cnt_r;
  reg  [4:0]  accepted_r;
  reg         accepted_nm_r;
  reg  [7:0]  rdata_nxt;
  reg  [25:0] latch_nxt;

  wire [NSRC*2-1:0] level_bus;
  wire [25:0]       candidate;
  wire              accept_now;

  // The core stacks this flag on acceptance and pops it on return.
  assign master_enable = master_enable_r;

  // Level fields for sources 4 to 25.
  // Four fields share each register address, two at the last; a write updates all of them, each taking its own slot.
  genvar g;
  generate
    for (g = 4; g < NSRC; g = g + 1)
    begin : gen_level
      level_field #(
        .REG_INDEX ((g - 4) / 4),
        .SLOT      ((g - 4) % 4)
      ) u_level (
        .clk     (clk),
        .rst_n   (rst_n),
        .ce      (ce),
        .wr_en   (wr_en),
        .addr    (addr),
        .wdata   (wdata),
        .level_r (level_bus[g*2 +: 2])
      );
    end
    for (g = 0; g < 4; g = g + 1)
    begin : gen_unused_level
      assign level_bus[g*2 +: 2] = 2'h0;
    end
  endgenerate

  // A source competes only when latched, enabled and master is set.
  // Sources 0 to 3 never latch, so they never enter the chain.
  assign candidate = request_latch_r & source_enable_flag_r &
                     {NSRC{master_enable_r}};

  // Linear arbitration chain over the candidates.
  // Each step keeps the better of the chain so far and the next source, so the
  // last step holds the overall winner. The chain is long but small, and
  // twenty-six two-input steps fit easily in one system clock.
  // The chain starts empty: no valid entry, level zero and index zero.
  wire [NSRC:0]       ch_valid;
  wire [NSRC*2+1:0]   ch_level;
  wire [NSRC*5+4:0]   ch_index;
  assign ch_valid[0]       = 1'b0;
  assign ch_level[1:0]     = 2'h0;
  assign ch_index[4:0]     = 5'h00;
  generate
    for (g = 0; g < NSRC; g = g + 1)
    begin : gen_pick
      priority_pick u_pick (
        .a_valid (candidate[g]),
        .a_level (level_bus[g*2 +: 2]),
        .a_index (g[4:0]),
        .b_valid (ch_valid[g]),
        .b_level (ch_level[g*2 +: 2]),
        .b_index (ch_index[g*5 +: 5]),
        .w_valid (ch_valid[g+1]),
        .w_level (ch_level[(g+1)*2 +: 2]),
        .w_index (ch_index[(g+1)*5 +: 5])
      );
    end
  endgenerate

  // Acceptance starts only at a boundary and only from idle; this is what
  // blocks nesting, since a second request waits until the return.
  assign accept_now = instr_boundary && state_r == ST_IDLE &&
                      (nonmask_pending_r || ch_valid[NSRC]);

  // Winner presented to the core.
  // The index is registered so that the core sees a value that stays steady
  // for a whole cycle.
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      winner_index_r <= 5'h00;
      winner_valid_r <= 1'b0;
    end
    else if (ce)
    begin
      winner_valid_r <= nonmask_pending_r | ch_valid[NSRC];
      winner_index_r <= nonmask_pending_r ? `NONMASK_INDEX
                        : ch_index[NSRC*5 +: 5];
    end
  end

  // Latch next value: sets from sources win over clears.
  // Clears come from writes and from acceptance; a request pulse in the same
  // cycle sets the bit again, so no event is lost. Writing one never sets a
  // latch, so a read-modify-write cannot raise a false request.
  always @*
  begin
    latch_nxt = request_latch_r;
    if (wr_en)
    begin
      case (addr)
        `ADDR_LATCH_LOW:   latch_nxt[7:4]   = request_latch_r[7:4] & wdata[7:4];
        `ADDR_LATCH_HIGH:  latch_nxt[15:8]  = request_latch_r[15:8] & wdata;
        `ADDR_LATCH_16_23: latch_nxt[23:16] = request_latch_r[23:16] & wdata;
        `ADDR_LATCH_24_25: latch_nxt[25:24] = request_latch_r[25:24] & wdata[1:0];
        default:           latch_nxt = request_latch_r;
      endcase
    end
    if (accept_now && !nonmask_pending_r)
      latch_nxt[ch_index[NSRC*5 +: 5]] = 1'b0;
    latch_nxt = (latch_nxt | src_request) & 26'h3FFFFF0;
  end

  // Registers, flags and latches.
  // Acceptance clears the master flag after any write in the same cycle, so a
  // write that sets it cannot reopen the window during acceptance. A return
  // reloads the flag from the value that the core popped.
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      source_enable_flag_r <= 26'h0000000;
      master_enable_r      <= 1'b0;
      request_latch_r      <= 26'h0000000;
      nonmask_pending_r    <= 1'b0;
    end
    else if (ce)
    begin
      request_latch_r <= latch_nxt;
      if (nonmask_request)
        nonmask_pending_r <= 1'b1;
      else if (accept_now && nonmask_pending_r)
        nonmask_pending_r <= 1'b0;
      if (wr_en)
      begin
        case (addr)
          `ADDR_ENABLE_LOW:
          begin
            source_enable_flag_r[7:4] <= wdata[7:4];
            master_enable_r           <= wdata[`MASTER_BIT];
          end
          `ADDR_ENABLE_HIGH:   source_enable_flag_r[15:8]  <= wdata;
          `ADDR_ENABLE_16_23:  source_enable_flag_r[23:16] <= wdata;
          `ADDR_ENABLE_24_25:  source_enable_flag_r[25:24] <= wdata[1:0];
          default:             source_enable_flag_r <= source_enable_flag_r;
        endcase
      end
      if (accept_now)
        master_enable_r <= 1'b0;
      else if (maskable_return || nonmaskable_return)
        master_enable_r <= restored_master;
    end
  end

  // Bits 3 and 2 of the upper enable register store but do nothing.
  reg [1:0] spare_enable_r;
  always @(posedge clk)
  begin
    if (!rst_n)
      spare_enable_r <= 2'h0;
    else if (ce && wr_en && addr == `ADDR_ENABLE_24_25)
      spare_enable_r <= wdata[3:2];
  end

  // Bits 7 to 4 of the last level register store but do nothing.
  reg [3:0] spare_level_r;
  always @(posedge clk)
  begin
    if (!rst_n)
      spare_level_r <= 4'h0;
    else if (ce && wr_en && addr == `ADDR_LEVEL_LAST)
      spare_level_r <= wdata[7:4];
  end

  // Read data.
  // Unmapped addresses and reserved bits read as zero; spare enable and level bits read back as written.
  always @*
  begin
    case (addr)
      `ADDR_ENABLE_LOW:   rdata_nxt = {source_enable_flag_r[7:4], 3'h0,
                                       master_enable_r};
      `ADDR_ENABLE_HIGH:  rdata_nxt = source_enable_flag_r[15:8];
      `ADDR_ENABLE_16_23: rdata_nxt = source_enable_flag_r[23:16];
      `ADDR_ENABLE_24_25: rdata_nxt = {4'h0, spare_enable_r,
                                       source_enable_flag_r[25:24]};
      `ADDR_LATCH_LOW:    rdata_nxt = {request_latch_r[7:4], 4'h0};
      `ADDR_LATCH_HIGH:   rdata_nxt = request_latch_r[15:8];
      `ADDR_LATCH_16_23:  rdata_nxt = request_latch_r[23:16];
      `ADDR_LATCH_24_25:  rdata_nxt = {6'h00, request_latch_r[25:24]};
      `ADDR_LEVEL_BASE:   rdata_nxt = level_bus[15:8];
      `ADDR_LEVEL_8_11:   rdata_nxt = level_bus[23:16];
      `ADDR_LEVEL_12_15:  rdata_nxt = level_bus[31:24];
      `ADDR_LEVEL_16_19:  rdata_nxt = level_bus[39:32];
      `ADDR_LEVEL_20_23:  rdata_nxt = level_bus[47:40];
      `ADDR_LEVEL_LAST:   rdata_nxt = {spare_level_r, level_bus[51:48]};
      default:            rdata_nxt = `RESET_BYTE;
    endcase
  end

  // Read data is registered and holds until the next read strobe.
  always @(posedge clk)
  begin
    if (!rst_n)
      rdata_r <= `RESET_BYTE;
    else if (ce && rd_en)
      rdata_r <= rdata_nxt;
  end

  // Acceptance sequencer: eight machine cycles, three pushes, vector load.
  // The counter advances only on machine-cycle pulses, so the sequence keeps
  // its eight machine cycles whatever the ratio of system clock to machine
  // cycle. The first three machine cycles each push one byte: status with
  // the master flag, program counter high, then program counter low.
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_r        <= ST_IDLE;
      cycle_cnt_r    <= 4'h0;
      accepted_r     <= 5'h00;
      accepted_nm_r  <= 1'b0;
      accept_busy_r  <= 1'b0;
      push_strobe_r  <= 1'b0;
      push_count_r   <= 2'h0;
      vector_load_r  <= 1'b0;
      vector_index_r <= 5'h00;
      in_service_r   <= 1'b0;
    end
    else if (ce)
    begin
      push_strobe_r <= 1'b0;
      vector_load_r <= 1'b0;
      case (state_r)
        ST_IDLE:
        begin
          if (accept_now)
          begin
            state_r       <= ST_ACCEPT;
            accept_busy_r <= 1'b1;
            cycle_cnt_r   <= 4'h0;
            push_count_r  <= 2'h0;
            // A non-maskable request takes the slot ahead of any maskable winner.
            accepted_nm_r <= nonmask_pending_r;
            accepted_r    <= nonmask_pending_r ? `NONMASK_INDEX
                             : ch_index[NSRC*5 +: 5];
          end
        end
        ST_ACCEPT:
        begin
          if (machine_cycle)
          begin
            cycle_cnt_r <= cycle_cnt_r + 4'h1;
            if (push_count_r != `STACK_PUSH_COUNT)
            begin
              push_strobe_r <= 1'b1;
              push_count_r  <= push_count_r + 2'h1;
            end
            if (cycle_cnt_r == `ACCEPT_CYCLES - 4'h1)
            begin
              state_r        <= ST_SERVE;
              accept_busy_r  <= 1'b0;
              vector_load_r  <= 1'b1;
              vector_index_r <= accepted_r;
              in_service_r   <= 1'b1;
            end
          end
        end
        ST_SERVE:
        begin
          // Only the return that matches the kind of request ends service.
          if ((maskable_return && !accepted_nm_r) ||
              (nonmaskable_return && accepted_nm_r))
          begin
            state_r      <= ST_IDLE;
            in_service_r <= 1'b0;
          end
          else if (accept_now)
            state_r <= ST_SERVE;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end
endmodule

// file: intc_map.vh
// Operation
// - Enable register for sources 16 to 23
// - Enable register sources 24, 25; mixed bits
// - Each enable flag gates its own source
// - Master flag blocks all maskable acceptance
// - Acceptance clears master flag automatically
// - Lowest enable register unused bits read zero
// - Four programmable levels for sources 4-25
// - Greater level number wins arbitration
// - Equal levels: higher basic priority wins
// - All levels zero after reset
// - Four 2-bit fields per level register, two in the last
// - Further level registers cover remaining sources
// - Latched request pends until accepted or cleared
// - Acceptance sequence takes eight machine cycles
// - Service ends on matching return instruction
// - Writing zero clears latch, one ignored
// - Acceptance clears latch, pushes three, loads vector
// - Master flag at bit 0, reset zero
`ifndef INTC_MAP_VH
`define INTC_MAP_VH
`define ADDR_ENABLE_LOW     12'h03A
`define ADDR_ENABLE_HIGH    12'h03B
`define ADDR_ENABLE_16_23   12'h03C
`define ADDR_ENABLE_24_25   12'h03D
`define ADDR_LATCH_LOW      12'hFE0
`define ADDR_LATCH_HIGH     12'hFE1
`define ADDR_LATCH_16_23    12'hFE2
`define ADDR_LATCH_24_25    12'hFE3
`define ADDR_LEVEL_BASE     12'hFF0
`define ADDR_LEVEL_8_11     12'hFF1
`define ADDR_LEVEL_12_15    12'hFF2
`define ADDR_LEVEL_16_19    12'hFF3
`define ADDR_LEVEL_20_23    12'hFF4
`define ADDR_LEVEL_LAST     12'hFF5
`define MASTER_BIT          0
`define RESET_BYTE          8'h00
`define ACCEPT_CYCLES       4'h8
`define STACK_PUSH_COUNT    2'h3
`define FIRST_SOURCE        5
`define LAST_SOURCE         25
`define NONMASK_INDEX       5'h00
`endif

// file: level_field.v
`include "intc_map.vh"
// Holds one source's 2-bit level inside a level register byte.
module level_field #(
  parameter REG_INDEX = 0,
  parameter SLOT      = 0
) (
  // Clock and reset
  input  wire       clk,
  input  wire       rst_n,
  input  wire       ce,
  // Register write
  input  wire       wr_en,
  input  wire [11:0] addr,
  input  wire [7:0] wdata,
  // Level out
  output reg  [1:0] level_r
);
  wire [11:0] my_addr;
  assign my_addr = `ADDR_LEVEL_BASE + REG_INDEX[11:0];
  always @(posedge clk)
  begin
    if (!rst_n)
      level_r <= 2'h0;
    else if (ce && wr_en && addr == my_addr)
      level_r <= wdata[SLOT*2 +: 2];
  end
endmodule

// file: priority_pick.v
// Two-way arbitration step: greater level wins, ties to higher source index.
module priority_pick (
  // Candidate a
  input  wire       a_valid,
  input  wire [1:0] a_level,
  input  wire [4:0] a_index,
  // Candidate b
  input  wire       b_valid,
  input  wire [1:0] b_level,
  input  wire [4:0] b_index,
  // Winner
  output wire       w_valid,
  output wire [1:0] w_level,
  output wire [4:0] w_index
);
  wire take_a;
  // Higher index means higher basic priority.
  assign take_a  = a_valid && (!b_valid || a_level > b_level ||
                   (a_level == b_level && a_index > b_index));
  assign w_valid = a_valid | b_valid;
  assign w_level = take_a ? a_level : b_level;
  assign w_index = take_a ? a_index : b_index;
endmodule

// file: accept_checker_sva.sv
module accept_checker (
  // Clock and reset
  input logic       clk,
  input logic       rst_n,
  // Core side
  input logic       rd_en,
  input logic       instr_boundary,
  input logic       machine_cycle,
  input logic       maskable_return,
  input logic       nonmaskable_return,
  // Status
  input logic [7:0] rdata_r,
  input logic       accept_busy_r,
  input logic       push_strobe_r,
  input logic       vector_load_r,
  input logic [4:0] vector_index_r,
  input logic       in_service_r,
  input logic       master_enable
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] mc_cnt_r;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Counts machine cycles seen during one acceptance.
  always @(posedge clk)
  begin
    if (!rst_n || !accept_busy_r)
      mc_cnt_r <= 4'h0;
    else if (machine_cycle)
      mc_cnt_r <= mc_cnt_r + 4'h1;
  end
  AST_MASTER_DROP: assert property ($rose(accept_busy_r) |-> !master_enable)
    else $error("master flag set after acceptance");
  AST_AT_BOUNDARY: assert property ($rose(accept_busy_r) |-> $past(instr_boundary))
    else $error("acceptance off a boundary");
  AST_PUSH_IN_BUSY: assert property (push_strobe_r |-> accept_busy_r)
    else $error("push outside acceptance");
  AST_EIGHT_CYCLES: assert property (accept_busy_r && machine_cycle |-> mc_cnt_r < 4'h8)
    else $error("acceptance longer than eight cycles");
  AST_VECTOR_AFTER_EIGHT: assert property (vector_load_r |-> mc_cnt_r == 4'h8)
    else $error("vector load not after eight machine cycles");
  AST_VECTOR_PULSE: assert property (vector_load_r |=> !vector_load_r && in_service_r)
    else $error("vector load not followed by service");
  AST_INDEX_HOLDS: assert property (in_service_r && $past(in_service_r) |-> $stable(vector_index_r))
    else $error("vector index moved in service");
  AST_RETURN_ENDS: assert property (in_service_r && (vector_index_r == 5'h00 ?
    nonmaskable_return : maskable_return) |=> !in_service_r)
    else $error("service not ended by return");
  AST_NO_NEST: assert property (in_service_r |-> !$rose(accept_busy_r))
    else $error("acceptance while in service");
  AST_RDATA_HOLD: assert property (!rd_en |=> $stable(rdata_r))
    else $error("read data changed without read");
  cover property ($rose(vector_load_r));
  cover property (in_service_r && maskable_return);
  cover property (in_service_r && nonmaskable_return);
endmodule
bind interrupt_enable_priority_logic accept_checker u_accept_checker (
  .clk(clk), .rst_n(rst_n), .rd_en(rd_en), .instr_boundary(instr_boundary),
  .machine_cycle(machine_cycle), .maskable_return(maskable_return),
  .nonmaskable_return(nonmaskable_return), .rdata_r(rdata_r),
  .accept_busy_r(accept_busy_r), .push_strobe_r(push_strobe_r),
  .vector_load_r(vector_load_r), .vector_index_r(vector_index_r),
  .in_service_r(in_service_r), .master_enable(master_enable));

// file: core_model.sv
module core_model (
  // Clock and reset
  input  logic       clk,
  input  logic       rst_n,
  // Bench control
  input  logic       slow,
  input  logic       ret_go,
  // Device status
  input  logic       accept_busy_r,
  input  logic       in_service_r,
  input  logic       master_enable,
  input  logic [4:0] vector_index_r,
  // Core sequencing
  output logic       machine_cycle,
  output logic       instr_boundary,
  output logic       maskable_return,
  output logic       nonmaskable_return,
  output logic       restored_master
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] div_r;
  logic       held_r;
  // The stacked master flag is frozen from acceptance until the return.
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      div_r <= 2'h0;
      held_r <= 1'b0;
      restored_master <= 1'b0;
    end
    else
    begin
      div_r <= div_r + 2'h1;
      if (maskable_return || nonmaskable_return)
        held_r <= 1'b0;
      else if (accept_busy_r)
        held_r <= 1'b1;
      else if (!held_r)
        restored_master <= master_enable;
    end
  end
  assign machine_cycle = rst_n && (!slow || div_r == 2'h3);
  assign instr_boundary = machine_cycle;
  assign maskable_return = ret_go && in_service_r && vector_index_r != 5'h00;
  assign nonmaskable_return = ret_go && in_service_r && vector_index_r == 5'h00;
endmodule

// file: interrupt_enable_priority_logic_bench.sv
module interrupt_enable_priority_logic_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, rst_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0;
  logic        nonmask_request = 1'b0, slow = 1'b0, ret_go = 1'b0;
  logic        ce = 1'b1, winner_valid_r;
  logic [4:0]  winner_index_r;
  logic [1:0]  push_count_r;
  logic [11:0] addr = 12'h000;
  logic [7:0]  wdata = 8'h00;
  logic [25:0] src_request = 26'h0;
  logic [7:0]  rdata_r, w;
  logic        machine_cycle, instr_boundary, maskable_return, nonmaskable_return;
  logic        restored_master, accept_busy_r, push_strobe_r, vector_load_r;
  logic        in_service_r, master_enable;
  logic [4:0]  vector_index_r;
  logic [7:0]  lv [6];
  logic [25:0] pend;
  int          n_mismatch = 0;
  int          checks = 0;
  always #5 clk = ~clk;
  interrupt_enable_priority_logic u_interrupt_enable_priority_logic (
    .clk(clk), .rst_n(rst_n), .ce(ce), .addr(addr), .wr_en(wr_en), .rd_en(rd_en),
    .wdata(wdata), .rdata_r(rdata_r), .src_request(src_request),
    .nonmask_request(nonmask_request), .instr_boundary(instr_boundary),
    .machine_cycle(machine_cycle), .maskable_return(maskable_return),
    .nonmaskable_return(nonmaskable_return), .restored_master(restored_master),
    .winner_index_r(winner_index_r), .winner_valid_r(winner_valid_r),
    .accept_busy_r(accept_busy_r), .push_strobe_r(push_strobe_r),
    .push_count_r(push_count_r), .vector_load_r(vector_load_r),
    .vector_index_r(vector_index_r), .in_service_r(in_service_r),
    .master_enable(master_enable));
  core_model u_core_model (
    .clk(clk), .rst_n(rst_n), .slow(slow), .ret_go(ret_go),
    .accept_busy_r(accept_busy_r), .in_service_r(in_service_r),
    .master_enable(master_enable), .vector_index_r(vector_index_r),
    .machine_cycle(machine_cycle), .instr_boundary(instr_boundary),
    .maskable_return(maskable_return), .nonmaskable_return(nonmaskable_return),
    .restored_master(restored_master));
  function automatic logic [1:0] lvl(input int s);
    lvl = lv[(s - 4) / 4][2 * ((s - 4) % 4) +: 2];
  endfunction
  // Greater level wins; the ascending scan hands ties to the higher source.
  function automatic logic [4:0] win(input logic [25:0] p);
    logic [4:0] b;
    begin
      b = 5'h00;
      for (int s = 8; s < 26; s++)
        if (p[s] && (b == 5'h00 || lvl(s) >= lvl(b)))
          b = s[4:0];
      win = b;
    end
  endfunction
  task automatic end_sim;
    begin
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  task automatic chk(input logic [25:0] seen, input logic [25:0] exp);
    begin
      checks++;
      if (seen !== exp)
      begin
        n_mismatch++;
        $display("mismatch at %0t: got %h want %h", $time, seen, exp);
      end
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    begin
      @(negedge clk);
      addr = a;
      wdata = d;
      wr_en = 1'b1;
      @(negedge clk);
      wr_en = 1'b0;
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    begin
      @(negedge clk);
      addr = a;
      rd_en = 1'b1;
      @(negedge clk);
      rd_en = 1'b0;
      chk({18'h0, rdata_r}, {18'h0, e});
    end
  endtask
  task automatic serve(input logic [4:0] e);
    logic [25:0] p;
    int          n;
    begin
      p = 26'h0;
      n = 0;
      while (vector_load_r !== 1'b1 && n < 400)
      begin
        @(negedge clk);
        p = p + push_strobe_r;
        n++;
      end
      if (n == 400)
      begin
        n_mismatch++;
        end_sim;
      end
      chk(vector_index_r, e);
      chk(p, 26'h3);
      chk(push_count_r, 2'h3);
      chk(master_enable, 1'b0);
      if (e != 5'h00)
        pend[e] = 1'b0;
      rd(12'hFE1, pend[15:8]);
      rd(12'hFE2, pend[23:16]);
      rd(12'hFE3, {6'h00, pend[25:24]});
      ret_go = 1'b1;
      @(negedge clk);
      ret_go = 1'b0;
      @(negedge clk);
      chk(in_service_r, 1'b0);
    end
  endtask
  initial
  begin
    void'($urandom(32'h8d5e));
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    rd(12'h03A, 8'h00);
    rd(12'h03C, 8'h00);
    rd(12'h03D, 8'h00);
    for (int k = 0; k < 6; k++)
      rd(12'(12'hFF0 + k), 8'h00);
    rd(12'h100, 8'h00);
    wr(12'h03D, 8'hFF);
    rd(12'h03D, 8'h0F);
    wr(12'h03A, 8'h0E);
    rd(12'h03A, 8'h00);
    w = $urandom;
    wr(12'h03C, w);
    rd(12'h03C, w);
    ce = 1'b0;
    wr(12'h03C, ~w);
    ce = 1'b1;
    rd(12'h03C, w);
    wr(12'hFE2, 8'hFF);
    rd(12'hFE2, 8'h00);
    wr(12'h03B, 8'hFF);
    wr(12'h03C, 8'hFF);
    wr(12'h03D, 8'h03);
    $display("test registers done");
    for (int t = 0; t < 6; t++)
    begin
      slow = t[0];
      wr(12'h03A, 8'h00);
      for (int k = 0; k < 6; k++)
      begin
        lv[k] = $urandom;
        wr(12'(12'hFF0 + k), lv[k]);
        rd(12'(12'hFF0 + k), lv[k]);
      end
      pend = (26'h1 << (8 + $urandom % 18)) | (26'h1 << (8 + $urandom % 18)) | 26'h10;
      src_request = pend;
      nonmask_request = (t == 0);
      @(negedge clk);
      src_request = 26'h0;
      nonmask_request = 1'b0;
      if (t == 0)
      begin
        @(negedge clk);
        chk(winner_valid_r, 1'b1);
        chk(winner_index_r, 5'h00);
        serve(5'h00);
      end
      repeat (20) @(negedge clk);
      chk(accept_busy_r, 1'b0);
      chk(winner_valid_r, 1'b0);
      chk(winner_index_r, 5'h00);
      wr(12'h03A, 8'h01);
      for (int i = 0; i < 3 && pend[25:8] != 18'h0; i++)
        serve(win(pend));
      rd(12'hFE0, 8'h10);
      wr(12'hFE0, 8'h00);
      rd(12'hFE0, 8'h00);
      $display("test trial %0d done", t);
    end
    end_sim;
  end
endmodule
